//--- src/pdacc_pkg.sv
// constants and types of the power-down clock control
// Behaviour
// - State select: 0,1 low, 2 ultra, 3 off.
// - Measure select picks none, discrete or continuous mixes asleep.
// - Low bias bit gives ten percent bias asleep.
// - Ultra bias bit gives five percent bias asleep.
// - Both bias bits give fifteen percent.
// - Refbuf cancellation powered asleep only while measuring.
// - Key write, then chip select rise, enters power-down.
// - Discrete mixes: counted current-only runs before each full measurement.
// - Base clock 4MHz in full power, 125kHz asleep.
// - Shared modulator clock and chop clock.
// - Full power modulator clock is 4MHz over twice divider.
// - Full power divider zero gives 2MHz.
// - Chop clock is modulator over two to chop field plus one.
// - Modulator base lags by position plus one fast cycles.
// - Chop base shifted zero to four fast cycles.
// - Chop delay is chop minus modulator position, modulo five.
// - Asleep, modulator is 125kHz over twice divider; zero gives 62.5kHz.
// - On wake, full power config returns before processor clock.
package pdacc_pkg;
   localparam logic [7:0] ADDR_FULL_POWER_CONFIG      = 8'h53;
   localparam logic [7:0] ADDR_DISCRETE_CURRENT_COUNT = 8'h5f;
   localparam logic [7:0] ADDR_POWER_DOWN_CONFIG      = 8'h64;
   localparam logic [7:0] ADDR_POWER_DOWN_TRIGGER     = 8'h65;
   localparam logic [7:0] ADDR_LP_DIV_LO              = 8'hb0;
   localparam logic [7:0] ADDR_LP_DIV_HI              = 8'hb1;
   localparam logic [7:0] ADDR_FP_CFG_LO              = 8'hb2;
   localparam logic [7:0] ADDR_FP_CFG_HI              = 8'hb3;

   localparam logic [7:0] TRIGGER_KEY = 8'ha9;

   localparam logic [7:0] RST_FULL_POWER_CONFIG = 8'h00;
   localparam logic [7:0] RST_POWER_DOWN_CONFIG = 8'h20;
   localparam logic [7:0] RST_DISCRETE_COUNT    = 8'h00;
   localparam logic [9:0] RST_LP_DIV            = 10'h018;
   localparam logic [9:0] RST_FP_DIV            = 10'h008;
   localparam logic [2:0] RST_CHOP_POS          = 3'h2;
   localparam logic [1:0] RST_MOD_POS           = 2'h2;

   localparam int FPC_POWER_LO   = 0;
   localparam int FPC_POWER_HI   = 1;
   localparam int FPC_CUT_LOW    = 3;
   localparam int FPC_CUT_ULTRA  = 4;
   localparam int FPC_REFBUF_OFF = 5;
   localparam logic [7:0] FPC_WRITE_MASK = 8'h3b;

   localparam logic [1:0] SEL_ULTRA = 2'h2;
   localparam logic [1:0] SEL_OFF   = 2'h3;

   localparam logic [2:0] MEAS_NONE     = 3'h0;
   localparam logic [2:0] MEAS_DISC_CUR = 3'h1;
   localparam logic [2:0] MEAS_DISC_INT = 3'h2;
   localparam logic [2:0] MEAS_DISC_EXT = 3'h3;

   localparam logic [1:0] PWR_FULL  = 2'h0;
   localparam logic [1:0] PWR_LOW   = 2'h1;
   localparam logic [1:0] PWR_ULTRA = 2'h2;
   localparam logic [1:0] PWR_OFF   = 2'h3;

   localparam logic [1:0] BIAS_FULL = 2'h0;

   localparam int unsigned REF_CLK_HZ = 200_000_000;
   localparam int unsigned HP_OSC_HZ  = 20_000_000;
   localparam int unsigned FP_BASE_HZ = 4_000_000;
   localparam int unsigned LP_BASE_HZ = 125_000;
   localparam int unsigned HP_TICK_CYCLES = REF_CLK_HZ / HP_OSC_HZ;
   localparam int unsigned LP_TICK_CYCLES = REF_CLK_HZ / LP_BASE_HZ;
   localparam int unsigned FP_PHASES      = HP_OSC_HZ / FP_BASE_HZ;
   localparam logic [3:0]  HP_TICK_LAST   = 4'(HP_TICK_CYCLES - 1);
   localparam logic [10:0] LP_TICK_LAST   = 11'(LP_TICK_CYCLES - 1);
   localparam logic [10:0] LP_HIGH_COUNT  = 11'(LP_TICK_CYCLES / 2);
   localparam logic [2:0]  FP_PHASE_LAST  = 3'(FP_PHASES - 1);
   localparam logic [2:0]  FP_HIGH_PHASES = 3'(FP_PHASES / 2);
   localparam logic [3:0]  FP_PHASE_COUNT = 4'(FP_PHASES);

   typedef struct packed {
      logic       refbuf_power;
      logic       cut_ultra;
      logic       cut_low;
      logic [2:0] measure;
      logic [1:0] state;
   } pdacc_sleep_cfg_type;

   typedef struct packed {
      logic       stopped;
      logic       low_power;
      logic [9:0] half;
      logic [1:0] chop_div;
      logic [2:0] mod_phase;
      logic [2:0] chop_phase;
   } pdacc_clk_cfg_type;

   typedef enum logic [2:0] {
      PS_FULL,
      PS_LOW,
      PS_ULTRA,
      PS_OFF,
      PS_WAKE
   } pdacc_state_type;
endpackage : pdacc_pkg

//--- src/pdacc_clk_gen.sv
// modulator and chop dividers
`timescale 1ns/1ps
module pdacc_clk_gen
   import pdacc_pkg::*;
#(
   parameter int DIV_W = 10
)
(
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             mod_tick_i,
   input  wire logic             chop_tick_i,
   input  wire logic             restart_i,
   input  wire logic [DIV_W-1:0] half_i,
   input  wire logic [1:0]       chop_div_i,
   output logic                  mod_clk_o,
   output logic                  chop_clk_o,
   output logic                  boundary_o
);
   logic [DIV_W-1:0] mod_cnt;
   logic [DIV_W-1:0] next_mod_cnt;
   logic [5:0]       idx;
   logic [5:0]       next_idx;
   logic [DIV_W+4:0] chop_cnt;
   logic [DIV_W+4:0] next_chop_cnt;
   logic             next_mod_clk;
   logic             next_chop_clk;
   logic [DIV_W-1:0] n_eff;
   logic [DIV_W+4:0] chop_last;
   logic [5:0]       idx_last;
   logic             mod_wrap;
   logic             chop_wrap;
   logic             chop_hold;
   logic             next_chop_hold;
   logic             chop_go;

   always_comb
   begin
      // zero divider acts as one
      n_eff = (half_i == '0) ? DIV_W'(1) : half_i;
      chop_last = ((DIV_W+5)'(n_eff) << (3'(chop_div_i) + 3'h1)) - (DIV_W+5)'(1);
      idx_last = (6'h04 << chop_div_i) - 6'h01;
      mod_wrap = mod_tick_i && (mod_cnt == n_eff - DIV_W'(1));
      chop_go = chop_tick_i && (!chop_hold || mod_tick_i);
      chop_wrap = chop_go && (chop_cnt == chop_last);
      boundary_o = mod_wrap && (idx == idx_last);
      next_mod_cnt = mod_cnt;
      next_idx = idx;
      next_chop_cnt = chop_cnt;
      next_mod_clk = mod_clk_o;
      next_chop_clk = chop_clk_o;
      next_chop_hold = chop_hold && !mod_tick_i;
      if (restart_i)
      begin
         next_mod_cnt = '0;
         next_idx = '0;
         next_chop_cnt = '0;
         next_mod_clk = 1'b0;
         next_chop_clk = 1'b0;
         next_chop_hold = 1'b1;
      end
      else
      begin
         if (mod_tick_i)
         begin
            next_mod_cnt = mod_wrap ? '0 : mod_cnt + DIV_W'(1);
         end
         if (mod_wrap)
         begin
            next_mod_clk = ~mod_clk_o;
            next_idx = boundary_o ? '0 : idx + 6'h01;
         end
         if (chop_go)
         begin
            next_chop_cnt = chop_wrap ? '0 : chop_cnt + (DIV_W+5)'(1);
         end
         if (chop_wrap)
         begin
            next_chop_clk = ~chop_clk_o;
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         mod_cnt <= '0;
         idx <= '0;
         chop_cnt <= '0;
         mod_clk_o <= 1'b0;
         chop_clk_o <= 1'b0;
         chop_hold <= 1'b1;
      end
      else
      begin
         mod_cnt <= next_mod_cnt;
         idx <= next_idx;
         chop_cnt <= next_chop_cnt;
         mod_clk_o <= next_mod_clk;
         chop_clk_o <= next_chop_clk;
         chop_hold <= next_chop_hold;
      end
   end
endmodule : pdacc_clk_gen

//--- src/pdacc_ctrl.sv
// power-down control and converter clocks
`timescale 1ns/1ps
module pdacc_ctrl
   import pdacc_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_write_i,
   input  wire logic       reg_read_i,
   input  wire logic       chip_select_n_i,
   input  wire logic       wake_i,
   input  wire logic       measure_trigger_i,
   input  wire logic       measurement_active_i,
   input  wire logic [1:0] chop_divider_i,
   output logic [7:0]      reg_rdata_o,
   output logic [1:0]      power_state_o,
   output logic            cpu_clock_enable_o,
   output logic [1:0]      bias_select_o,
   output logic            refbuf_cancel_power_o,
   output logic [1:0]      analog_power_o,
   output logic            measure_start_o,
   output logic [2:0]      measure_kind_o,
   output logic            base_clk_o,
   output logic            mod_clk_o,
   output logic            chop_clk_o
);
   // register file
   logic [7:0]          full_power_config;
   logic [7:0]          next_full_power_config;
   pdacc_sleep_cfg_type power_down_config;
   pdacc_sleep_cfg_type next_power_down_config;
   logic [7:0]          discrete_current_count;
   logic [7:0]          next_discrete_current_count;
   logic [9:0]          low_power_mod_divider;
   logic [9:0]          next_low_power_mod_divider;
   logic [9:0]          full_power_mod_divider;
   logic [9:0]          next_full_power_mod_divider;
   logic [2:0]          chop_clock_position;
   logic [2:0]          next_chop_clock_position;
   logic [1:0]          mod_clock_position;
   logic [1:0]          next_mod_clock_position;
   logic [7:0]          next_rdata;
   logic                key_write;

   always_comb
   begin
      next_full_power_config = full_power_config;
      next_power_down_config = power_down_config;
      next_discrete_current_count = discrete_current_count;
      next_low_power_mod_divider = low_power_mod_divider;
      next_full_power_mod_divider = full_power_mod_divider;
      next_chop_clock_position = chop_clock_position;
      next_mod_clock_position = mod_clock_position;
      next_rdata = reg_rdata_o;
      key_write = 1'b0;
      if (reg_write_i)
      begin
         case (reg_addr_i)
            ADDR_FULL_POWER_CONFIG: next_full_power_config = reg_wdata_i & FPC_WRITE_MASK;
            ADDR_POWER_DOWN_CONFIG: next_power_down_config = reg_wdata_i;
            ADDR_DISCRETE_CURRENT_COUNT: next_discrete_current_count = reg_wdata_i;
            ADDR_LP_DIV_LO: next_low_power_mod_divider[7:0] = reg_wdata_i;
            ADDR_LP_DIV_HI: next_low_power_mod_divider[9:8] = reg_wdata_i[1:0];
            ADDR_FP_CFG_LO: next_full_power_mod_divider[7:0] = reg_wdata_i;
            ADDR_FP_CFG_HI:
            begin
               next_full_power_mod_divider[9:8] = reg_wdata_i[1:0];
               next_chop_clock_position = reg_wdata_i[5:3];
               next_mod_clock_position = reg_wdata_i[7:6];
            end
            ADDR_POWER_DOWN_TRIGGER: key_write = 1'b1;
            default: key_write = 1'b0;
         endcase
      end
      if (reg_read_i)
      begin
         case (reg_addr_i)
            ADDR_FULL_POWER_CONFIG: next_rdata = full_power_config;
            ADDR_POWER_DOWN_CONFIG: next_rdata = power_down_config;
            ADDR_DISCRETE_CURRENT_COUNT: next_rdata = discrete_current_count;
            ADDR_LP_DIV_LO: next_rdata = low_power_mod_divider[7:0];
            ADDR_LP_DIV_HI: next_rdata = {6'h00, low_power_mod_divider[9:8]};
            ADDR_FP_CFG_LO: next_rdata = full_power_mod_divider[7:0];
            ADDR_FP_CFG_HI:
               next_rdata = {mod_clock_position, chop_clock_position, 1'b0,
                             full_power_mod_divider[9:8]};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         full_power_config <= RST_FULL_POWER_CONFIG;
         power_down_config <= RST_POWER_DOWN_CONFIG;
         discrete_current_count <= RST_DISCRETE_COUNT;
         low_power_mod_divider <= RST_LP_DIV;
         full_power_mod_divider <= RST_FP_DIV;
         chop_clock_position <= RST_CHOP_POS;
         mod_clock_position <= RST_MOD_POS;
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         full_power_config <= next_full_power_config;
         power_down_config <= next_power_down_config;
         discrete_current_count <= next_discrete_current_count;
         low_power_mod_divider <= next_low_power_mod_divider;
         full_power_mod_divider <= next_full_power_mod_divider;
         chop_clock_position <= next_chop_clock_position;
         mod_clock_position <= next_mod_clock_position;
         reg_rdata_o <= next_rdata;
      end
   end

   // chip select sync and state machine
   logic            cs_meta;
   logic            cs_sync;
   logic            cs_prev;
   logic            armed;
   logic            next_armed;
   pdacc_state_type state;
   pdacc_state_type next_state;
   logic            cs_rise;

   always_comb
   begin
      cs_rise = cs_sync && !cs_prev;
      next_armed = armed;
      next_state = state;
      case (state)
         PS_FULL:
         begin
            if (cs_rise && armed)
            begin
               next_armed = 1'b0;
               case (power_down_config.state)
                  SEL_ULTRA: next_state = PS_ULTRA;
                  SEL_OFF: next_state = PS_OFF;
                  default: next_state = PS_LOW;
               endcase
            end
         end
         PS_LOW, PS_ULTRA, PS_OFF:
         begin
            if (wake_i)
            begin
               next_state = PS_WAKE;
            end
         end
         // config restored, cpu clock next
         PS_WAKE: next_state = PS_FULL;
         default: next_state = PS_FULL;
      endcase
      if (key_write)
      begin
         next_armed = (reg_wdata_i == TRIGGER_KEY);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
         armed <= 1'b0;
         state <= PS_FULL;
      end
      else
      begin
         cs_meta <= chip_select_n_i;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         armed <= next_armed;
         state <= next_state;
      end
   end

   // discrete sequencing
   logic [7:0] disc_cnt;
   logic [7:0] next_disc_cnt;
   logic       next_measure_start;
   logic [2:0] next_measure_kind;
   logic       asleep_meas;

   always_comb
   begin
      asleep_meas = (state == PS_LOW) || (state == PS_ULTRA);
      next_disc_cnt = disc_cnt;
      next_measure_start = 1'b0;
      next_measure_kind = measure_kind_o;
      if (!asleep_meas)
      begin
         next_disc_cnt = 8'h00;
      end
      else if (measure_trigger_i && (power_down_config.measure != MEAS_NONE))
      begin
         next_measure_start = 1'b1;
         next_measure_kind = power_down_config.measure;
         if ((power_down_config.measure == MEAS_DISC_INT) ||
             (power_down_config.measure == MEAS_DISC_EXT))
         begin
            if (disc_cnt < discrete_current_count)
            begin
               next_measure_kind = MEAS_DISC_CUR;
               next_disc_cnt = disc_cnt + 8'h01;
            end
            else
            begin
               next_disc_cnt = 8'h00;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         disc_cnt <= 8'h00;
         measure_start_o <= 1'b0;
         measure_kind_o <= MEAS_NONE;
      end
      else
      begin
         disc_cnt <= next_disc_cnt;
         measure_start_o <= next_measure_start;
         measure_kind_o <= next_measure_kind;
      end
   end

   // base clock events
   logic [3:0]  hp_cnt;
   logic [3:0]  next_hp_cnt;
   logic [2:0]  fp_phase;
   logic [2:0]  next_fp_phase;
   logic [10:0] lp_cnt;
   logic [10:0] next_lp_cnt;
   logic        hp_tick;
   logic        lp_tick;

   always_comb
   begin
      hp_tick = (hp_cnt == HP_TICK_LAST);
      lp_tick = (lp_cnt == LP_TICK_LAST);
      next_hp_cnt = hp_tick ? 4'h0 : hp_cnt + 4'h1;
      next_lp_cnt = lp_tick ? 11'h000 : lp_cnt + 11'h001;
      next_fp_phase = fp_phase;
      if (hp_tick)
      begin
         next_fp_phase = (fp_phase == FP_PHASE_LAST) ? 3'h0 : fp_phase + 3'h1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         hp_cnt <= 4'h0;
         fp_phase <= 3'h0;
         lp_cnt <= 11'h000;
      end
      else
      begin
         hp_cnt <= next_hp_cnt;
         fp_phase <= next_fp_phase;
         lp_cnt <= next_lp_cnt;
      end
   end

   // clock configuration, applied at chop boundary
   pdacc_clk_cfg_type wanted_cfg;
   pdacc_clk_cfg_type active_cfg;
   pdacc_clk_cfg_type next_active_cfg;
   logic              cfg_valid;
   logic              next_cfg_valid;
   logic              boundary;
   logic              restart;
   logic              mod_tick;
   logic              chop_tick;
   logic [3:0]        chop_sum;

   always_comb
   begin
      chop_sum = 4'(chop_clock_position) + 4'h1;
      wanted_cfg.stopped = (state == PS_OFF);
      wanted_cfg.low_power = (state == PS_LOW) || (state == PS_ULTRA);
      wanted_cfg.half = wanted_cfg.low_power ? low_power_mod_divider
                                             : full_power_mod_divider;
      wanted_cfg.chop_div = chop_divider_i;
      wanted_cfg.mod_phase = 3'(mod_clock_position) + 3'h1;
      wanted_cfg.chop_phase = (chop_sum >= FP_PHASE_COUNT) ? 3'(chop_sum - FP_PHASE_COUNT)
                                                           : 3'(chop_sum);
      restart = (wanted_cfg != active_cfg) &&
                (boundary || active_cfg.stopped || !cfg_valid);
      next_active_cfg = restart ? wanted_cfg : active_cfg;
      next_cfg_valid = 1'b1;
      if (active_cfg.stopped)
      begin
         mod_tick = 1'b0;
         chop_tick = 1'b0;
      end
      else if (active_cfg.low_power)
      begin
         // asleep, no edge shift
         mod_tick = lp_tick;
         chop_tick = lp_tick;
      end
      else
      begin
         mod_tick = hp_tick && (next_fp_phase == active_cfg.mod_phase);
         chop_tick = hp_tick && (next_fp_phase == active_cfg.chop_phase);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         active_cfg <= '0;
         cfg_valid <= 1'b0;
      end
      else
      begin
         active_cfg <= next_active_cfg;
         cfg_valid <= next_cfg_valid;
      end
   end

   pdacc_clk_gen #(
      .DIV_W (10)
   ) u_clk_gen (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i),
      .mod_tick_i  (mod_tick),
      .chop_tick_i (chop_tick),
      .restart_i   (restart),
      .half_i      (active_cfg.half),
      .chop_div_i  (active_cfg.chop_div),
      .mod_clk_o   (mod_clk_o),
      .chop_clk_o  (chop_clk_o),
      .boundary_o  (boundary)
   );

   // registered outputs
   logic [1:0] next_power_state;
   logic       next_cpu_clock_enable;
   logic [1:0] next_bias_select;
   logic       next_refbuf;
   logic [1:0] next_analog_power;
   logic       next_base_clk;

   always_comb
   begin
      next_cpu_clock_enable = (state == PS_FULL);
      next_power_state = PWR_FULL;
      next_bias_select = {full_power_config[FPC_CUT_ULTRA], full_power_config[FPC_CUT_LOW]};
      next_refbuf = !full_power_config[FPC_REFBUF_OFF];
      next_analog_power = full_power_config[FPC_POWER_HI:FPC_POWER_LO];
      next_base_clk = (fp_phase < FP_HIGH_PHASES);
      case (state)
         PS_LOW, PS_ULTRA:
         begin
            next_power_state = (state == PS_LOW) ? PWR_LOW : PWR_ULTRA;
            // code 1 ten, 2 five, 3 fifteen percent bias
            next_bias_select = {power_down_config.cut_ultra,
                                power_down_config.cut_low};
            next_refbuf = power_down_config.refbuf_power && measurement_active_i &&
                          (power_down_config.measure != MEAS_NONE);
            next_analog_power = {2{power_down_config.measure != MEAS_NONE}};
            next_base_clk = (lp_cnt < LP_HIGH_COUNT);
         end
         PS_OFF:
         begin
            next_power_state = PWR_OFF;
            next_bias_select = BIAS_FULL;
            next_refbuf = 1'b0;
            next_analog_power = 2'h0;
            next_base_clk = 1'b0;
         end
         default: next_power_state = PWR_FULL;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         power_state_o <= PWR_FULL;
         cpu_clock_enable_o <= 1'b0;
         bias_select_o <= BIAS_FULL;
         refbuf_cancel_power_o <= 1'b0;
         analog_power_o <= 2'h0;
         base_clk_o <= 1'b0;
      end
      else
      begin
         power_state_o <= next_power_state;
         cpu_clock_enable_o <= next_cpu_clock_enable;
         bias_select_o <= next_bias_select;
         refbuf_cancel_power_o <= next_refbuf;
         analog_power_o <= next_analog_power;
         base_clk_o <= next_base_clk;
      end
   end
endmodule : pdacc_ctrl

//--- sim/pdacc_host_model.sv
// register host model
`timescale 1ns/1ps
module pdacc_host_model
(
   input  wire logic  ref_clk_i,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic       reg_write_o,
   output logic       reg_read_o,
   output logic       chip_select_n_o
);
   initial {reg_addr_o, reg_wdata_o, reg_write_o, reg_read_o, chip_select_n_o} = 19'h1;
   // released address and data lines show inverted values; write and read strobes drop to zero
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(negedge ref_clk_i);
      chip_select_n_o = 1'h0;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_write_o = w;
      reg_read_o = !w;
      @(negedge ref_clk_i);
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
      reg_write_o = 1'h0;
      reg_read_o = 1'h0;
   endtask : xfer
   task automatic finish_select();
      @(negedge ref_clk_i);
      chip_select_n_o = 1'h1;
   endtask : finish_select
endmodule : pdacc_host_model

//--- sim/pdacc_ctrl_assertions.sv
// port assertions of the control
`timescale 1ns/1ps
module pdacc_ctrl_assertions
   import pdacc_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       reset_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_read_i,
   input wire logic       chip_select_n_i,
   input wire logic       wake_i,
   input wire logic       measure_trigger_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [1:0] power_state_o,
   input wire logic       cpu_clock_enable_o,
   input wire logic       measure_start_o,
   input wire logic [2:0] measure_kind_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   entry_release_a: assert property (
      $changed(power_state_o) && $past(power_state_o) == PWR_FULL |-> $past(chip_select_n_i, 2))
      else $error("entry without release");
   wake_cpu_a: assert property (
      wake_i && power_state_o != PWR_FULL |=> !cpu_clock_enable_o [*2] ##1 cpu_clock_enable_o)
      else $error("bad wake");
   asleep_cpu_a: assert property (
      power_state_o != PWR_FULL && $past(power_state_o) != PWR_FULL |-> !cpu_clock_enable_o)
      else $error("cpu clock asleep");
   start_cause_a: assert property (measure_start_o |-> $past(measure_trigger_i))
      else $error("start without trigger");
   start_kind_a: assert property (measure_start_o |-> measure_kind_o != MEAS_NONE)
      else $error("empty kind");
   start_asleep_a: assert property (measure_start_o |-> !cpu_clock_enable_o)
      else $error("start while awake");
   trig_read_a: assert property (
      reg_read_i && reg_addr_i == ADDR_POWER_DOWN_TRIGGER |=> reg_rdata_o == 8'h00)
      else $error("trigger readable");
   lp_hi_read_a: assert property (
      reg_read_i && reg_addr_i == ADDR_LP_DIV_HI |=> reg_rdata_o[7:2] == 6'h00)
      else $error("unused bits set");
endmodule : pdacc_ctrl_assertions
bind pdacc_ctrl pdacc_ctrl_assertions chk_u (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_read_i,
   .chip_select_n_i, .wake_i, .measure_trigger_i, .reg_rdata_o, .power_state_o,
   .cpu_clock_enable_o, .measure_start_o, .measure_kind_o);

//--- sim/pdacc_ctrl_bench.sv
// self-checking control bench
`timescale 1ns/1ps
module pdacc_ctrl_bench;
   import pdacc_pkg::*;
   logic       ref_clk_i, reset_n_i = 1'h0, wake_i = 1'h0, measure_trigger_i = 1'h0;
   logic       measurement_active_i = 1'h0, reg_write_i, reg_read_i, chip_select_n_i;
   logic       cpu_clock_enable_o, refbuf_cancel_power_o, measure_start_o, base_clk_o;
   logic       mod_clk_o, chop_clk_o, rd_d = 1'h0, mod_q = 1'h0, chop_q = 1'h0;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q[$];
   logic [1:0] chop_divider_i, power_state_o, bias_select_o, analog_power_o;
   logic [2:0] measure_kind_o;
   int         err_total = 0, samples_checked = 0, cyc = 0, n, lr, pr, lc, pc, le, dly;
   int         fpb = REF_CLK_HZ / FP_BASE_HZ;
   pdacc_host_model host_u (.ref_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_write_o(reg_write_i), .reg_read_o(reg_read_i), .chip_select_n_o(chip_select_n_i));
   pdacc_ctrl dut_u (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
      .reg_read_i, .chip_select_n_i, .wake_i, .measure_trigger_i, .measurement_active_i,
      .chop_divider_i, .reg_rdata_o, .power_state_o, .cpu_clock_enable_o, .bias_select_o,
      .refbuf_cancel_power_o, .analog_power_o, .measure_start_o, .measure_kind_o,
      .base_clk_o, .mod_clk_o, .chop_clk_o);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask : idle
   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge ref_clk_i);
      s = 1'h0;
   endtask : pulse
   task automatic sleep_work();
      measurement_active_i = 1'h1;
      idle(3);
      chk(refbuf_cancel_power_o, 16'h1);
      measurement_active_i = 1'h0;
      idle(3);
      chk(refbuf_cancel_power_o, 16'h0);
      for (int j = 0; j < 2 * n + 2; j++)
      begin
         q.push_back(j % (n + 1) == n ? 8'h02 : 8'h01);
         pulse(measure_trigger_i);
         idle(3);
      end
      chk(16'(q.size()), 16'h0);
      idle(8000);
      chk(16'(lr - pr), 16'(2 * LP_TICK_CYCLES));
   endtask : sleep_work
   task automatic give_verdict();
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   initial
   begin
      ref_clk_i = 1'h0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   initial
   begin
      #400us;
      err_total++;
      give_verdict();
   end
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      rd_d <= reg_read_i;
   end
   always @(negedge ref_clk_i)
   begin
      if (rd_d || measure_start_o)
         chk(rd_d ? reg_rdata_o : 8'(measure_kind_o), q.size() ? q.pop_front() : 8'hxx);
      if (mod_clk_o !== mod_q)
         le = cyc;
      if (mod_clk_o && !mod_q)
      begin
         pr = lr;
         lr = cyc;
      end
      if (chop_clk_o && !chop_q)
      begin
         pc = lc;
         lc = cyc;
         dly = cyc - le;
      end
      mod_q = mod_clk_o;
      chop_q = chop_clk_o;
   end
   initial
   begin
      void'($urandom(1));
      chop_divider_i = 2'($urandom % 2);
      n = $urandom % 3 + 1;
      idle(3);
      reset_n_i = 1'h1;
      for (int i = 0; i < 9; i++)
         q.push_back(72'h002000001800089000 >> (64 - 8 * i));
      for (int i = 0; i < 9; i++)
         host_u.xfer(8'(72'h53645f65b0b1b2b310 >> (64 - 8 * i)), 8'h00, 1'h0);
      host_u.xfer(ADDR_DISCRETE_CURRENT_COUNT, 8'(n), 1'h1);
      host_u.finish_select();
      idle(8);
      chk(power_state_o, 16'(PWR_FULL));
      q.push_back(8'(n));
      host_u.xfer(ADDR_DISCRETE_CURRENT_COUNT, 8'h00, 1'h0);
      host_u.xfer(ADDR_FP_CFG_LO, 8'h02, 1'h1);
      for (int i = 0; i < 4; i++)
      begin
         host_u.xfer(ADDR_FP_CFG_HI, 8'(32'h909888c0 >> (24 - 8 * i)), 1'h1);
         idle(5000);
         chk(16'(lr - pr), 16'(4 * fpb));
         chk(16'(lc - pc), 16'((4 * fpb) << (chop_divider_i + 1)));
         chk(16'(dly), 16'(HP_TICK_CYCLES * 8'(32'h00010402 >> (24 - 8 * i))));
      end
      host_u.xfer(ADDR_FP_CFG_LO, 8'h00, 1'h1);
      host_u.xfer(ADDR_LP_DIV_LO, 8'h01, 1'h1);
      idle(2000);
      chk(16'(lr - pr), 16'(2 * fpb));
      for (int i = 0; i < 4; i++)
      begin
         host_u.xfer(ADDR_POWER_DOWN_CONFIG, 8'(32'he8214203 >> (24 - 8 * i)), 1'h1);
         host_u.xfer(ADDR_POWER_DOWN_TRIGGER, TRIGGER_KEY, 1'h1);
         host_u.finish_select();
         idle(8);
         chk(power_state_o, 16'(2'(8'h5b >> (6 - 2 * i))));
         if (i < 3)
            chk({bias_select_o, analog_power_o}, 16'(4'(12'hf48 >> (8 - 4 * i))));
         if (i == 0)
            sleep_work();
         pulse(wake_i);
         idle(4);
         chk({power_state_o, cpu_clock_enable_o}, 16'h1);
      end
      give_verdict();
   end
endmodule : pdacc_ctrl_bench
